// File: shared/clkdiv_pkg.sv
// Package for the clock divider sequencer: register field layout, reset values and timing.
// Assumes a single 100 MHz core clock; reference clocks arrive as synchronous sampled levels.
package clkdiv_pkg;

  // Mode word field positions
  localparam int MODE_WIDTH         = 9;
  localparam int REF_SOURCE_POS     = 0;
  localparam int DIV_BYPASS_POS     = 1;
  localparam int PRESC_BYPASS_POS   = 2;
  localparam int PRESC_RATIO_POS    = 3;
  localparam int PIN_FUNCTION_POS   = 4;
  localparam int REF_OUT_DIS_POS    = 5;

  // Divisor word; reset values of both words
  localparam int DIVISOR_WIDTH      = 9;
  localparam logic [DIVISOR_WIDTH-1:0] DIVISOR_MAX = 9'h1ff;
  localparam logic [DIVISOR_WIDTH-1:0] DIVISOR_RESET = 9'h000;
  localparam logic [MODE_WIDTH-1:0] MODE_RESET = 9'h034;

  // Stabilisation wait in master clock cycles
  localparam int STAB_CYCLES        = 256;
  localparam int STAB_WIDTH         = 9;

  // Decoded mode fields
  typedef struct packed {
    logic refOutDisable;
    logic pinFunction;
    logic prescRatio;
    logic prescBypass;
    logic divBypass;
    logic refSource;
  } mode_fields_s;

  // Power sequencer states
  typedef enum logic [2:0] {
    PWR_OFF,
    PWR_STAB,
    PWR_REFON,
    PWR_RUN,
    PWR_GATEOFF,
    PWR_MAINHIZ
  } pwr_state_e;

endpackage

// File: design/clkdiv_counter.sv
// Programmable divider: divides master-clock enable pulses by divisor code plus 2.
// Assumes tick is a one-cycle master clock enable; clear restarts from the reset state.
`timescale 1ns/100ps
`default_nettype none
module clkdiv_counter
  import clkdiv_pkg::*;
#(
  parameter int WIDTH = clkdiv_pkg::DIVISOR_WIDTH
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  // Control
  input  wire logic             tick,
  input  wire logic             clear,
  input  wire logic [WIDTH-1:0] divisor,
  // Result
  output logic                  divOut,
  output logic                  wrap
);
  logic [WIDTH:0] count_reg;
  logic [WIDTH:0] terminal;
  logic [WIDTH:0] half;

  // Terminal count is divisor code plus one, so the period is code plus 2
  assign terminal = {1'b0, divisor} + {{WIDTH{1'b0}}, 1'b1};
  // High slots per period, rounded up; a cleared counter rises on its first tick, which
  // keeps the restart after the gate within one master period
  assign half = (terminal + {{(WIDTH-1){1'b0}}, 2'b10}) >> 1;
  assign wrap = tick && (count_reg == terminal);

  // Count master ticks; output high for the first half of each period
  always_ff @(posedge core_clk) begin
    if (!rst_n || clear) begin
      count_reg <= '0;
      divOut    <= 1'b0;
    end else if (tick) begin
      if (count_reg == terminal) begin
        count_reg <= '0;
      end else begin
        count_reg <= count_reg + 1'b1;
      end
      divOut <= (count_reg < half);
    end
  end
endmodule
`default_nettype wire

// File: design/clock_sequencer.sv
// Clock generator core: reference select, prescaler, divider and enabling sequencer.
// Assumes reference clocks are sampled levels synchronous to core_clk (well below 50 MHz).
`timescale 1ns/100ps
`default_nettype none
module clock_sequencer
  import clkdiv_pkg::*;
#(
  parameter int STAB_COUNT = clkdiv_pkg::STAB_CYCLES
) (
  // Clock and reset
  input  wire logic                                core_clk,
  input  wire logic                                rst_n,
  // Configuration words
  input  wire logic [clkdiv_pkg::MODE_WIDTH-1:0]    mode_word,
  input  wire logic [clkdiv_pkg::DIVISOR_WIDTH-1:0] divisor_word,
  // Reference sources
  input  wire logic                                internal_oscillator,
  input  wire logic                                external_oscillator_input,
  // Control pins
  input  wire logic                                multi_function_pin,
  input  wire logic                                outputGate,
  // Main output pin
  output logic                                     mainOut,
  output logic                                     mainOutEn,
  // Reference clock pin
  output logic                                     reference_clock_pin,
  output logic                                     refOutEn,
  // Oscillator enable
  output logic                                     oscEnable
);
  import clkdiv_pkg::*;

  mode_fields_s mode;
  assign mode = mode_fields_s'({mode_word[REF_OUT_DIS_POS], mode_word[PIN_FUNCTION_POS],
                                mode_word[PRESC_RATIO_POS], mode_word[PRESC_BYPASS_POS],
                                mode_word[DIV_BYPASS_POS], mode_word[REF_SOURCE_POS]});

  // Pin function decode
  logic reference_select_input;
  logic powerDownReq;
  assign reference_select_input = mode.pinFunction ? 1'b1 : multi_function_pin;
  assign powerDownReq = mode.pinFunction && !multi_function_pin;

  // Wanted source: 1 means external
  logic wantExt;
  assign wantExt = mode.pinFunction ? mode.refSource : !reference_select_input;

  pwr_state_e pwrState_reg;
  logic forceMax;
  assign forceMax = (pwrState_reg == PWR_STAB);

  // Prescaler on the internal oscillator, edge detect and toggle dividers
  logic oscPrev_reg;
  logic [1:0] presc_reg;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      oscPrev_reg <= 1'b0;
      presc_reg   <= 2'b00;
    end else if (oscEnable) begin
      oscPrev_reg <= internal_oscillator;
      if (internal_oscillator && !oscPrev_reg) begin
        presc_reg <= presc_reg + 2'b01;
      end
    end
  end

  // Internal reference clock choice
  logic useDiv2;
  logic bypassPresc;
  logic internal_reference_clock;
  assign bypassPresc = !forceMax && (mode.prescBypass || mode.divBypass);
  assign useDiv2 = mode.prescRatio && !forceMax;
  always_comb begin
    if (bypassPresc) begin
      internal_reference_clock = internal_oscillator;
    end else if (useDiv2) begin
      internal_reference_clock = presc_reg[0];
    end else begin
      internal_reference_clock = presc_reg[1];
    end
  end

  // External reference comes straight from the oscillator input
  logic external_reference_clock;
  assign external_reference_clock = external_oscillator_input;

  // Sampled copies of both references
  logic intPrev_reg;
  logic extPrev_reg;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      intPrev_reg <= 1'b0;
      extPrev_reg <= 1'b0;
    end else begin
      intPrev_reg <= internal_reference_clock;
      extPrev_reg <= external_reference_clock;
    end
  end
  logic intFall;
  logic intRise;
  assign intFall = intPrev_reg && !internal_reference_clock;
  assign intRise = !intPrev_reg && internal_reference_clock;

  // Glitch-free reference switch
  typedef enum logic [1:0] {SW_INT, SW_HOLD_E, SW_EXT, SW_HOLD_I} sw_state_e;
  sw_state_e swState_reg;
  logic holdDone_reg;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      swState_reg  <= SW_INT;
      holdDone_reg <= 1'b0;
    end else begin
      case (swState_reg)
        SW_INT: begin
          if (wantExt && intFall) begin
            swState_reg  <= SW_HOLD_E;
            holdDone_reg <= 1'b0;
          end
        end
        SW_HOLD_E: begin
          if (intRise) begin
            holdDone_reg <= 1'b1; // Half internal period of low has passed
          end
          if ((holdDone_reg || intRise) && !external_reference_clock) begin
            swState_reg <= SW_EXT;
          end
        end
        SW_EXT: begin
          if (!wantExt && !external_reference_clock) begin
            swState_reg <= SW_HOLD_I; // Level triggered, stalls on high input
          end
        end
        SW_HOLD_I: begin
          if (intFall) begin
            swState_reg <= SW_INT; // Next internal rise passes
          end
        end
        default: begin
          swState_reg <= SW_INT;
        end
      endcase
    end
  end

  // Master clock from the active source, forced low during handover
  logic masterClk;
  always_comb begin
    case (swState_reg)
      SW_INT:  masterClk = internal_reference_clock;
      SW_EXT:  masterClk = external_reference_clock;
      default: masterClk = 1'b0;
    endcase
  end

  logic masterPrev_reg;
  logic masterTick;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      masterPrev_reg <= 1'b0;
    end else begin
      masterPrev_reg <= masterClk;
    end
  end
  assign masterTick = masterClk && !masterPrev_reg && (pwrState_reg != PWR_OFF);

  // Output gate sampled on master rising edges
  logic gateSampled_reg;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      gateSampled_reg <= 1'b0;
    end else if (masterTick) begin
      gateSampled_reg <= outputGate && (pwrState_reg == PWR_RUN);
    end
  end

  // Divider with forced maximum during stabilisation
  logic [DIVISOR_WIDTH-1:0] divisorUsed;
  logic divOut;
  logic divWrap;
  logic divClear;
  assign divisorUsed = forceMax ? DIVISOR_MAX : divisor_word;
  assign divClear = !gateSampled_reg && !mainOut; // Divider counter held reset while gated
  clkdiv_counter #(
    .WIDTH(DIVISOR_WIDTH)
  ) u_counter (
    .core_clk(core_clk),
    .rst_n   (rst_n),
    .tick    (masterTick),
    .clear   (divClear),
    .divisor (divisorUsed),
    .divOut  (divOut),
    .wrap    (divWrap)
  );

  // Main output: gated divider, or master clock in divide-by-one; high pulses finish
  logic mainNext;
  always_comb begin
    if (mode.divBypass && !forceMax) begin
      mainNext = masterClk && (gateSampled_reg || mainOut);
    end else if (gateSampled_reg || mainOut) begin
      mainNext = divOut && !(divClear);
    end else begin
      mainNext = 1'b0;
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mainOut <= 1'b0;
    end else if (mode.divBypass && !forceMax) begin
      mainOut <= mainNext;
    end else if (mainOut && !gateSampled_reg) begin
      mainOut <= divOut; // Let the current high pulse complete
    end else begin
      mainOut <= mainNext && gateSampled_reg;
    end
  end

  // Power sequencer with stabilisation counter
  logic [STAB_WIDTH-1:0] stabCount_reg;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pwrState_reg  <= PWR_STAB;
      stabCount_reg <= '0;
    end else begin
      case (pwrState_reg)
        PWR_OFF: begin
          if (!powerDownReq) begin
            pwrState_reg  <= PWR_STAB;
            stabCount_reg <= '0;
          end
        end
        PWR_STAB: begin
          if (masterTick) begin
            stabCount_reg <= stabCount_reg + 1'b1;
          end
          if (stabCount_reg == STAB_WIDTH'(STAB_COUNT - 1) && masterTick) begin
            pwrState_reg <= PWR_REFON;
          end
        end
        PWR_REFON: begin
          pwrState_reg <= PWR_RUN; // Reference pin enabled before main
        end
        PWR_RUN: begin
          if (powerDownReq) begin
            pwrState_reg <= PWR_GATEOFF;
          end
        end
        PWR_GATEOFF: begin
          if (!mainOut && !gateSampled_reg) begin
            pwrState_reg <= PWR_MAINHIZ;
          end
        end
        PWR_MAINHIZ: begin
          if (!masterClk) begin
            pwrState_reg <= PWR_OFF; // Stop master while low
          end
        end
        default: begin
          pwrState_reg <= PWR_STAB;
        end
      endcase
    end
  end

  // Pin drivers, all registered
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      reference_clock_pin <= 1'b0;
      refOutEn            <= 1'b0;
      mainOutEn           <= 1'b0;
      oscEnable           <= 1'b1;
    end else begin
      reference_clock_pin <= masterClk && (pwrState_reg inside {PWR_RUN, PWR_GATEOFF});
      refOutEn  <= !mode.refOutDisable && (pwrState_reg inside
                   {PWR_REFON, PWR_RUN, PWR_GATEOFF, PWR_MAINHIZ});
      mainOutEn <= (pwrState_reg == PWR_RUN) || (pwrState_reg == PWR_GATEOFF);
      oscEnable <= (pwrState_reg != PWR_OFF);
    end
  end

  // Checks
  a_div_period: assert property (@(posedge core_clk) disable iff (!rst_n)
    (divWrap && !divClear) |=> !divOut)
    else $error("divider output still high after its wrap");
  a_gated_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!gateSampled_reg && !mainOut) |=> !divOut)
    else $error("divider not held in reset while gated");
  a_gate_off_low: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!gateSampled_reg && !mainOut && !mode.divBypass) |=> !mainOut)
    else $error("main output rose while gated off");
  a_pd_main_hiz: assert property (@(posedge core_clk) disable iff (!rst_n)
    (pwrState_reg == PWR_OFF) |=> !mainOutEn)
    else $error("main output driven in power-down");
  a_pd_ref_hiz: assert property (@(posedge core_clk) disable iff (!rst_n)
    (pwrState_reg == PWR_OFF) |=> !refOutEn)
    else $error("reference pin driven in power-down");
  a_ref_dis: assert property (@(posedge core_clk) disable iff (!rst_n)
    mode.refOutDisable |=> !refOutEn)
    else $error("reference pin driven while disabled");
  a_no_pd_sel: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!mode.pinFunction && pwrState_reg == PWR_RUN) |=> pwrState_reg == PWR_RUN)
    else $error("power-down taken in select mode");
  a_ext_low: assert property (@(posedge core_clk) disable iff (!rst_n)
    (swState_reg == SW_HOLD_E) |=>
      (swState_reg == SW_EXT) |-> !$past(external_reference_clock))
    else $error("external routed while high");
  a_stab_force: assert property (@(posedge core_clk) disable iff (!rst_n)
    (pwrState_reg == PWR_STAB) |-> (divisorUsed == DIVISOR_MAX) ##1 (!mainOutEn && !refOutEn))
    else $error("outputs enabled or divisor not forced during stabilisation");
  a_ref_first: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(mainOutEn) |-> (refOutEn || mode.refOutDisable))
    else $error("main output enabled before the reference output");
endmodule
`default_nettype wire

// File: test/clock_consumer.sv
// Board-side consumer of the generated clocks: counts main output rising edges and
// measures the spacing between them. Assumes the driver enables are high while driven.
`timescale 1ns/100ps
`default_nettype none
module clock_consumer (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // Main clock pin
  input  wire logic mainOut,
  input  wire logic mainOutEn,
  // Measurements
  output int        rises,
  output int        period
);
  logic mainPrev;
  int   sinceRise;

  // A floating pin reads low here, so only driven edges are counted
  always @(posedge core_clk) begin
    mainPrev <= mainOutEn & mainOut;
    sinceRise <= sinceRise + 1;
    if (!rst_n) begin
      rises <= 0;
      period <= 0;
    end else if ((mainOutEn & mainOut) && !mainPrev) begin
      rises <= rises + 1;
      period <= sinceRise;
      sinceRise <= 1;
    end
  end

  initial begin
    mainPrev = 1'b0;
    sinceRise = 0;
  end
endmodule
`default_nettype wire

// File: test/testbench.sv
// Self-checking bench for the clock sequencer: one task per scenario.
// Assumes references are slow square waves made here in core_clk cycles.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import clkdiv_pkg::*;
  localparam int INT_HALF = 4;
  localparam int EXT_HALF = 6;
  logic       core_clk, rst_n, internalOsc, externalOsc, selPin, outputGate;
  logic [8:0] modeWord, divisorWord;
  logic       mainOut, mainOutEn, refPin, refOutEn, oscEnable;
  int         rises, period, intCnt, extCnt, n_fail, comparisons;

  clock_sequencer #(.STAB_COUNT(4)) clock_sequencer_i (
    .core_clk(core_clk), .rst_n(rst_n), .mode_word(modeWord), .divisor_word(divisorWord),
    .internal_oscillator(internalOsc), .external_oscillator_input(externalOsc),
    .multi_function_pin(selPin), .outputGate(outputGate), .mainOut(mainOut),
    .mainOutEn(mainOutEn), .reference_clock_pin(refPin), .refOutEn(refOutEn),
    .oscEnable(oscEnable));
  clock_consumer clock_consumer_i (
    .core_clk(core_clk), .rst_n(rst_n), .mainOut(mainOut), .mainOutEn(mainOutEn),
    .rises(rises), .period(period));

  always #5 core_clk = ~core_clk;

  // Different periods for the two references, 8 and 12 core clock cycles; their edges line up every 12 cycles
  always @(posedge core_clk) begin
    intCnt <= (intCnt == INT_HALF - 1) ? 0 : intCnt + 1;
    if (intCnt == INT_HALF - 1) internalOsc <= ~internalOsc;
    extCnt <= (extCnt == EXT_HALF - 1) ? 0 : extCnt + 1;
    if (extCnt == EXT_HALF - 1) externalOsc <= ~externalOsc;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Mode words may not change while running, so each setup goes through reset
  task automatic setup(input logic [8:0] m, input logic [8:0] d);
    int i;
    @(posedge core_clk);
    rst_n <= 1'b0;
    modeWord <= m;
    divisorWord <= d;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    for (i = 0; i < 3000 && mainOutEn !== 1'b1; i++) @(posedge core_clk);
    if (mainOutEn !== 1'b1) n_fail++; // Start-up never finished
  endtask

  task automatic wait_rises(input int n);
    int start, i;
    start = rises;
    for (i = 0; i < 20000 && rises < start + n; i++) @(posedge core_clk);
    if (rises < start + n) n_fail++; // Main output stalled
  endtask

  // Rising edges of the reference pin over a window of core clock cycles
  task automatic count_ref(input int cycles, output int n);
    logic prev;
    int i;
    n = 0;
    prev = refPin;
    for (i = 0; i < cycles; i++) begin
      @(posedge core_clk);
      if (refPin === 1'b1 && prev === 1'b0) n++;
      prev = refPin;
    end
  endtask

  task automatic period_test(input logic [8:0] m, input logic [8:0] d, input int exp);
    setup(m, d);
    wait_rises(3);
    check(period, exp);
    $display("period test mode %h divisor %h done", m, d);
  endtask

  task automatic gate_test();
    int held, i, n;
    setup(9'h014, 9'h001);
    wait_rises(2);
    @(posedge core_clk);
    outputGate <= 1'b0;
    repeat (40) @(posedge core_clk);
    held = rises;
    repeat (100) @(posedge core_clk);
    check(rises, held);
    check(mainOut, 1'b0);
    check(refOutEn, 1'b1);
    count_ref(8 * 2 * INT_HALF, n);
    check(n, 8);
    outputGate <= 1'b1;
    for (i = 0; i < 100 && rises == held; i++) @(posedge core_clk);
    // One to two master periods, plus gate sampling, output register and edge counting
    check(i >= 2 * INT_HALF, 1'b1);
    check(i <= 2 * 2 * INT_HALF + 4, 1'b1);
    wait_rises(2);
    check(period, 3 * 2 * INT_HALF);
    $display("gate test done");
  endtask

  task automatic power_down_test();
    int i, n;
    setup(9'h014, 9'h001);
    check(refOutEn, 1'b1);
    check(oscEnable, 1'b1);
    count_ref(8 * 2 * INT_HALF, n);
    check(n, 8);
    selPin <= 1'b0;
    repeat (300) @(posedge core_clk);
    check(mainOutEn, 1'b0);
    check(refOutEn, 1'b0);
    check(oscEnable, 1'b0);
    count_ref(8 * 2 * INT_HALF, n);
    check(n, 0);
    selPin <= 1'b1;
    repeat (2) @(posedge core_clk);
    check(mainOutEn, 1'b0);
    for (i = 0; i < 3000 && refOutEn !== 1'b1; i++) @(posedge core_clk);
    check(mainOutEn, 1'b0);
    @(posedge core_clk);
    check(mainOutEn, 1'b1);
    wait_rises(3);
    check(refOutEn, 1'b1);
    check(period, 3 * 2 * INT_HALF);
    $display("power down test done");
  endtask

  task automatic select_test();
    setup(9'h004, 9'h001);
    wait_rises(3);
    check(period, 3 * 2 * INT_HALF);
    selPin <= 1'b0;
    wait_rises(4);
    check(period, 3 * 2 * EXT_HALF);
    selPin <= 1'b1;
    wait_rises(4);
    check(period, 3 * 2 * INT_HALF);
    $display("select test done");
  endtask

  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    internalOsc = 1'b0;
    externalOsc = 1'b0;
    selPin = 1'b1;
    outputGate = 1'b1;
    modeWord = 9'h034;
    divisorWord = 9'h000;
    intCnt = 0;
    extCnt = 0;
    n_fail = 0;
    comparisons = 0;
    setup(9'h034, 9'h000);
    check(refOutEn, 1'b0);
    wait_rises(3);
    check(period, 2 * 2 * INT_HALF);
    period_test(9'h014, 9'h001, 3 * 2 * INT_HALF);
    period_test(9'h014, 9'h000, 2 * 2 * INT_HALF);
    period_test(9'h014, 9'h1ff, 513 * 2 * INT_HALF);
    period_test(9'h018, 9'h001, 2 * 3 * 2 * INT_HALF);
    period_test(9'h010, 9'h001, 4 * 3 * 2 * INT_HALF);
    period_test(9'h012, 9'h001, 2 * INT_HALF);
    period_test(9'h01a, 9'h001, 2 * INT_HALF);
    period_test(9'h019, 9'h001, 3 * 2 * EXT_HALF);
    period_test(9'h013, 9'h001, 2 * EXT_HALF);
    gate_test();
    power_down_test();
    select_test();
    finish_test();
  end

  // Longest run is about 12,000 cycles; the limit sits at 50,000
  initial begin
    #500us;
    n_fail++;
    finish_test();
  end
endmodule
`default_nettype wire
